// file: inc/axis_ctrl_pkg.sv
// constants, register map and types for the single-axis start/stop/jog logic
// assumes pclk at 25 MHz and an apb master on the same clock
// How it works
// - a positioning run starts on the rising edge of the start input only.
// - a stop group selection of 1 gives a sudden stop using its own time in a positioning run; a stop during a jog is always a normal stop.
// - a repeated stop factor during a stop is ignored, mode kept.
// - speed and position phases share one speed, changeable after switch.
// - a reversing jog waits until the droop counter has reached zero.
// - jog limit above the overall limit flags an error and does not move.
package axis_ctrl_pkg;

    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned STOP_MIN_US   = 4000;
    localparam int unsigned STOP_MIN_CYC  =
        (STOP_MIN_US * (CLK_HZ / 1_000_000));

    // register byte offsets
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_STATUS     = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] OFF_SPEED      = 8'h10;
    localparam logic [7:0] OFF_DECEL      = 8'h14;
    localparam logic [7:0] OFF_SUDDEN     = 8'h18;
    localparam logic [7:0] OFF_JOG_LIM    = 8'h1C;
    localparam logic [7:0] OFF_SPD_LIM    = 8'h20;
    localparam logic [7:0] OFF_START_X    = 8'h24;
    localparam logic [7:0] OFF_CENTRE     = 8'h28;
    localparam logic [7:0] OFF_END        = 8'h2C;
    localparam logic [7:0] OFF_ABS_CTR    = 8'h30;
    localparam logic [7:0] OFF_ABS_END    = 8'h34;
    localparam logic [7:0] OFF_DROOP      = 8'h38;

    // control register bits
    localparam int unsigned CTRL_GRP1     = 0;
    localparam int unsigned CTRL_GRP2     = 1;
    localparam int unsigned CTRL_GRP3     = 2;
    localparam int unsigned CTRL_INC      = 3;
    localparam int unsigned CTRL_CHGOVER  = 4;
    localparam int unsigned CTRL_JOG_REV  = 5;
    localparam int unsigned CTRL_SGRP_LO  = 6;

    // interrupt bits
    localparam int unsigned IRQ_DONE      = 0;
    localparam int unsigned IRQ_STOP      = 1;
    localparam int unsigned IRQ_ERR       = 2;
    localparam int unsigned IRQ_W         = 3;

    localparam logic [15:0] ERR_JOG_LIMIT = 16'h0001;
    localparam logic [31:0] RESET_TIME    = 32'h0000_0010;
    localparam logic [31:0] RESET_SPEED   = 32'h0000_0100;

    typedef enum logic [1:0] {
        STOP_NONE,
        STOP_NORMAL,
        STOP_SUDDEN
    } stop_kind_t;

endpackage : axis_ctrl_pkg

// file: hdl/input_sync.sv
// three-stage synchroniser for an asynchronous pin
// assumes the pin is slow against pclk
`timescale 1ns/1ps
`default_nettype none
module input_sync
    import axis_ctrl_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output var  logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level <= s3_reg;
        end
    end
endmodule : input_sync
`default_nettype wire

// file: hdl/axis_start_stop_jog_control.sv
// single-axis start, stop and jog sequencing with an apb register file
// assumes the start, stop and jog pins are asynchronous to pclk
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module axis_start_stop_jog_control
    import axis_ctrl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        positioning_start_input,
    input  wire logic        axis_stop_input,
    input  wire logic        jog_start_input,
    input  wire logic        changeover_input,
    output var  logic        busy,
    output var  logic        axis_moving,
    output var  logic        irq
);
    ////////////////////////////////////////////////////////////////////////
    logic start_lvl, stop_lvl, jog_lvl, chg_lvl;
    logic start_d_reg, jog_d_reg, stop_d_reg;

    input_sync u_sync_start (.pclk(pclk), .presetn(presetn),
        .pin(positioning_start_input), .level(start_lvl));
    input_sync u_sync_stop (.pclk(pclk), .presetn(presetn),
        .pin(axis_stop_input), .level(stop_lvl));
    input_sync u_sync_jog (.pclk(pclk), .presetn(presetn),
        .pin(jog_start_input), .level(jog_lvl));
    input_sync u_sync_chg (.pclk(pclk), .presetn(presetn),
        .pin(changeover_input), .level(chg_lvl));

    // stop recognised only after a 4 ms continuous high
    logic [16:0] stop_cnt_reg;
    logic        stop_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_cnt_reg <= '0;
        end else if (!stop_lvl) begin
            stop_cnt_reg <= '0;
        end else if (stop_cnt_reg != 17'(STOP_MIN_CYC)) begin
            stop_cnt_reg <= stop_cnt_reg + 17'h00001;
        end
    end
    assign stop_ok = (stop_cnt_reg == 17'(STOP_MIN_CYC));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_d_reg <= 1'b0;
            jog_d_reg   <= 1'b0;
            stop_d_reg  <= 1'b0;
        end else begin
            start_d_reg <= start_lvl;
            jog_d_reg   <= jog_lvl;
            stop_d_reg  <= stop_ok;
        end
    end

    logic start_rise, jog_rise, stop_rise;
    assign start_rise = start_lvl & ~start_d_reg;
    assign jog_rise   = jog_lvl & ~jog_d_reg;
    assign stop_rise  = stop_ok & ~stop_d_reg;

    ////////////////////////////////////////////////////////////////////////
    logic [6:0]  ctrl_reg;
    logic [31:0] speed_reg, decel_reg, sudden_decel_time_reg;
    logic [31:0] jog_speed_limit_reg, overall_speed_limit_reg;
    logic [31:0] start_x_reg, centre_reg, end_reg;
    logic [31:0] abs_ctr_reg, abs_end_reg, droop_reg;
    logic [15:0] axis_error_number_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    logic        wr_en;
    logic [IRQ_W-1:0] irq_set;

    assign wr_en = psel & penable & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg                <= '0;
            speed_reg               <= RESET_SPEED;
            decel_reg               <= RESET_TIME;
            sudden_decel_time_reg   <= RESET_TIME;
            jog_speed_limit_reg     <= RESET_SPEED;
            overall_speed_limit_reg <= RESET_SPEED;
            start_x_reg             <= '0;
            centre_reg              <= '0;
            end_reg                 <= '0;
            irq_mask_reg            <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                OFF_CTRL:     ctrl_reg <= pwdata[6:0];
                // speed writable when idle, with changeover disabled, or once the changeover input is on
                OFF_SPEED: begin
                    if (!busy || !ctrl_reg[CTRL_CHGOVER] || chg_lvl) begin
                        speed_reg <= pwdata;
                    end
                end
                OFF_DECEL:    decel_reg <= pwdata;
                OFF_SUDDEN:   sudden_decel_time_reg <= pwdata;
                OFF_JOG_LIM:  jog_speed_limit_reg <= pwdata;
                OFF_SPD_LIM:  overall_speed_limit_reg <= pwdata;
                OFF_START_X:  start_x_reg <= pwdata;
                OFF_CENTRE:   centre_reg <= pwdata;
                OFF_END:      end_reg <= pwdata;
                OFF_IRQ_MASK: irq_mask_reg <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // incremental circular addresses relative to start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abs_ctr_reg <= '0;
            abs_end_reg <= '0;
        end else if (ctrl_reg[CTRL_INC]) begin
            abs_ctr_reg <= start_x_reg + centre_reg;
            abs_end_reg <= start_x_reg + end_reg;
        end else begin
            abs_ctr_reg <= centre_reg;
            abs_end_reg <= end_reg;
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                & ~((wr_en && paddr == OFF_IRQ_STAT) ?
                    pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        S_IDLE, S_RUN, S_JOG_WAIT, S_JOG, S_STOPPING
    } axis_state_t;
    axis_state_t state_reg;
    stop_kind_t  stop_kind_reg;
    logic [31:0] decel_cnt_reg;
    logic        sudden_sel;
    logic [1:0]  grp_sel;
    logic        run_done;

    assign grp_sel    = ctrl_reg[CTRL_SGRP_LO +: 1] == 1'b0 ? 2'h0 : 2'h2;
    // group selection 1 means sudden stop
    assign sudden_sel = ctrl_reg[grp_sel];
    // motion modelled as running until the run length counter expires
    assign run_done   = (decel_cnt_reg == 32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg             <= S_IDLE;
            stop_kind_reg         <= STOP_NONE;
            decel_cnt_reg         <= '0;
            axis_error_number_reg <= '0;
            droop_reg             <= '0;
            irq_set               <= '0;
        end else begin
            irq_set <= '0;
            unique case (state_reg)
                S_IDLE: begin
                    if (start_rise) begin
                        state_reg     <= S_RUN;
                        decel_cnt_reg <= speed_reg;
                    end else if (jog_rise) begin
                        if (jog_speed_limit_reg
                                > overall_speed_limit_reg) begin
                            axis_error_number_reg <= ERR_JOG_LIMIT;
                            irq_set[IRQ_ERR]      <= 1'b1;
                        end else if (ctrl_reg[CTRL_JOG_REV]) begin
                            state_reg <= S_JOG_WAIT;
                            droop_reg <= decel_reg;
                        end else begin
                            state_reg <= S_JOG;
                        end
                    end
                end
                S_RUN: begin
                    if (stop_rise) begin
                        state_reg     <= S_STOPPING;
                        stop_kind_reg <= sudden_sel ? STOP_SUDDEN
                                                    : STOP_NORMAL;
                        decel_cnt_reg <= sudden_sel ? sudden_decel_time_reg
                                                    : decel_reg;
                        irq_set[IRQ_STOP] <= 1'b1;
                    end else if (run_done) begin
                        state_reg        <= S_IDLE;
                        irq_set[IRQ_DONE] <= 1'b1;
                    end else begin
                        decel_cnt_reg <= decel_cnt_reg - 32'h0000_0001;
                    end
                end
                S_JOG_WAIT: begin
                    if (droop_reg == 32'h0000_0000) begin
                        state_reg <= S_JOG;
                    end else begin
                        droop_reg <= droop_reg - 32'h0000_0001;
                    end
                end
                S_JOG: begin
                    if (!jog_lvl || stop_rise) begin
                        state_reg     <= S_STOPPING;
                        stop_kind_reg <= STOP_NORMAL;
                        decel_cnt_reg <= decel_reg;
                    end
                end
                S_STOPPING: begin
                    if (run_done) begin
                        state_reg         <= S_IDLE;
                        stop_kind_reg     <= STOP_NONE;
                        irq_set[IRQ_DONE] <= 1'b1;
                    end else begin
                        decel_cnt_reg <= decel_cnt_reg - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // busy from accepted start to completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy        <= 1'b0;
            axis_moving <= 1'b0;
        end else begin
            busy        <= (state_reg != S_IDLE);
            axis_moving <= (state_reg == S_RUN) || (state_reg == S_JOG)
                        || (state_reg == S_STOPPING);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= (paddr > OFF_DROOP) || (paddr[1:0] != 2'h0);
                unique case (paddr)
                    OFF_CTRL:     prdata <= {25'h0, ctrl_reg};
                    OFF_STATUS:   prdata <= {axis_error_number_reg, 9'h0,
                                             state_reg, stop_kind_reg,
                                             axis_moving, busy};
                    OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_reg};
                    OFF_IRQ_MASK: prdata <= {29'h0, irq_mask_reg};
                    OFF_SPEED:    prdata <= speed_reg;
                    OFF_DECEL:    prdata <= decel_reg;
                    OFF_SUDDEN:   prdata <= sudden_decel_time_reg;
                    OFF_JOG_LIM:  prdata <= jog_speed_limit_reg;
                    OFF_SPD_LIM:  prdata <= overall_speed_limit_reg;
                    OFF_START_X:  prdata <= start_x_reg;
                    OFF_CENTRE:   prdata <= centre_reg;
                    OFF_END:      prdata <= end_reg;
                    OFF_ABS_CTR:  prdata <= abs_ctr_reg;
                    OFF_ABS_END:  prdata <= abs_end_reg;
                    OFF_DROOP:    prdata <= droop_reg;
                    default:      prdata <= '0;
                endcase
            end
        end
    end
endmodule : axis_start_stop_jog_control
`default_nettype wire

// file: tb/axis_chk.sv
// checker: apb timing and busy/motion relations of the axis block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module axis_chk
    import axis_ctrl_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        positioning_start_input,
    input wire logic        jog_start_input,
    input wire logic        busy,
    input wire logic        axis_moving
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       start_q;
    logic       jog_q;
    logic [3:0] since_edge;
    // cycles since a rising pin edge; saturates to mean long ago
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q    <= 1'b0;
            jog_q      <= 1'b0;
            since_edge <= 4'hF;
        end else begin
            start_q <= positioning_start_input;
            jog_q   <= jog_start_input;
            if ((positioning_start_input && !start_q) ||
                (jog_start_input && !jog_q))
                since_edge <= 4'h0;
            else if (since_edge != 4'hF)
                since_edge <= since_edge + 4'h1;
        end
    end
    ////////////////////////////////////////
    property p_zero_wait; psel && !penable |=> pready; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready long");
    property p_ready_acc; pready |-> psel && penable; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("stray pready");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
    property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read data");
    property p_busy_cause; $rose(busy) |-> since_edge <= 4'hA; endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy no edge");
    property p_idle_hold; !busy && since_edge > 4'hA |=> !busy; endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("busy on level");
    property p_move_busy; axis_moving |-> busy; endproperty
    a_move_busy: assert property (p_move_busy)
        else $error("moving idle");
    c_run: cover property ($rose(busy));
    c_move: cover property ($rose(axis_moving));
    c_err: cover property (pslverr);
endmodule : axis_chk
bind axis_start_stop_jog_control axis_chk axis_chk_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .positioning_start_input, .jog_start_input, .busy,
    .axis_moving);
`default_nettype wire

// file: tb/plc_model.sv
// controller model driving the start, stop, jog and changeover pins
// assumes the bench calls its tasks and pclk is the block's clock
`timescale 1ns/1ps
`default_nettype none
module plc_model
    import axis_ctrl_pkg::*;
(
    input  wire logic pclk,
    input  wire logic busy,
    output var  logic start_pin,
    output var  logic stop_pin,
    output var  logic jog_pin,
    output var  logic chg_pin
);
    initial begin
        start_pin = 1'b0;
        stop_pin  = 1'b0;
        jog_pin   = 1'b0;
        chg_pin   = 1'b0;
    end
    task automatic run(input bit keep);
        @(posedge pclk) start_pin <= 1'b1;
        // a hang here is ended by the bench watchdog
        while (busy !== 1'b1) @(posedge pclk);
        if (!keep) start_pin <= 1'b0;
    endtask : run
    task automatic drop;
        @(posedge pclk) start_pin <= 1'b0;
    endtask : drop
    task automatic stop(input int len);
        @(posedge pclk) stop_pin <= 1'b1;
        repeat (len) @(posedge pclk);
        while (len >= STOP_MIN_CYC && busy === 1'b1) @(posedge pclk);
        stop_pin <= 1'b0;
    endtask : stop
    task automatic set_jog(input logic v);
        @(posedge pclk) jog_pin <= v;
    endtask : set_jog
    task automatic set_chg(input logic v);
        @(posedge pclk) chg_pin <= v;
    endtask : set_chg
endmodule : plc_model
`default_nettype wire

// file: tb/tb_axis_start_stop_jog_control.sv
// self-checking bench for the single-axis start/stop/jog block
// assumes the controller model drives the pins, the bench drives apb
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin \
    compares++; \
    if ((s) !== (e)) begin \
        fails++; \
        $display("Error %s exp %h got %h", nm, e, s); \
    end \
end
module tb_axis_start_stop_jog_control
    import axis_ctrl_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        start, stop, jog, chg, busy, moving, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, s, c, e;
    logic [32:0] q[$];
    logic [32:0] exp;
    int          fails, compares;
    axis_start_stop_jog_control axis_start_stop_jog_control_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .positioning_start_input(start),
        .axis_stop_input(stop), .jog_start_input(jog),
        .changeover_input(chg), .busy, .axis_moving(moving), .irq);
    plc_model plc_model_i (.pclk, .busy, .start_pin(start),
        .stop_pin(stop), .jog_pin(jog), .chg_pin(chg));
    always #20 pclk = ~pclk;
    // read results leave the queue in issue order
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp = q.pop_front();
            `CHK("read", exp, {pslverr, prdata})
        end
    end
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic wait_busy(input logic v);
        int n = 0;
        while (busy !== v && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        `CHK("busy", v, busy)
    endtask : wait_busy
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(69369));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_SPEED, {1'b0, RESET_SPEED});
        rd(OFF_SUDDEN, {1'b0, RESET_TIME});
        rd(OFF_STATUS, 33'h0);
        rd(8'h3C, {1'b1, 32'h0});
        wr(OFF_SPEED, 32'h14);
        plc_model_i.run(1'b1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (20) @(posedge pclk);
        `CHK("busy", 1'b0, busy)
        plc_model_i.drop();
        `CHK("irq", 1'b0, irq)
        rd(OFF_IRQ_STAT, {1'b0, 32'h1});
        wr(OFF_IRQ_MASK, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        wr(OFF_IRQ_STAT, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        wr(OFF_SPEED, 32'h400);
        plc_model_i.run(1'b0);
        plc_model_i.stop(50);
        wait_busy(1'b0);
        rd(OFF_IRQ_STAT, {1'b0, 32'h1});
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_CTRL, 32'h10);
        wr(OFF_SPEED, 32'h100);
        plc_model_i.run(1'b0);
        wr(OFF_SPEED, 32'h20);
        rd(OFF_SPEED, {1'b0, 32'h100});
        plc_model_i.set_chg(1'b1);
        repeat (6) @(posedge pclk);
        wr(OFF_SPEED, 32'h20);
        rd(OFF_SPEED, {1'b0, 32'h20});
        wait_busy(1'b0);
        plc_model_i.set_chg(1'b0);
        s = $urandom;
        c = $urandom;
        e = $urandom;
        wr(OFF_CTRL, 32'h8);
        wr(OFF_START_X, s);
        wr(OFF_CENTRE, c);
        wr(OFF_END, e);
        plc_model_i.run(1'b0);
        wait_busy(1'b0);
        rd(OFF_ABS_CTR, {1'b0, s + c});
        rd(OFF_ABS_END, {1'b0, s + e});
        wr(OFF_CTRL, 32'h0);
        rd(OFF_ABS_CTR, {1'b0, c});
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_JOG_LIM, 32'h200);
        plc_model_i.set_jog(1'b1);
        repeat (12) @(posedge pclk);
        `CHK("moving", 1'b0, moving)
        `CHK("busy", 1'b0, busy)
        rd(OFF_IRQ_STAT, {1'b0, 32'h4});
        rd(OFF_STATUS, {1'b0, ERR_JOG_LIMIT, 16'h0});
        plc_model_i.set_jog(1'b0);
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_JOG_LIM, 32'h80);
        wr(OFF_CTRL, 32'h20);
        plc_model_i.set_jog(1'b1);
        repeat (8) @(posedge pclk);
        `CHK("moving", 1'b0, moving)
        repeat (100) if (moving !== 1'b1) @(posedge pclk);
        `CHK("moving", 1'b1, moving)
        rd(OFF_DROOP, 33'h0);
        plc_model_i.set_jog(1'b0);
        wait_busy(1'b0);
        final_report();
    end
endmodule : tb_axis_start_stop_jog_control
`default_nettype wire
